// *** lcdsd_top.sv ***
// Segment LCD driver control: register file, clock selection, prescaler, common scan.
// Assumes crystal and internal oscillator inputs are asynchronous, all else on clk_sys.
`timescale 1ns/1ps
module lcdsd_top
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic cpu_sleep,
   input wire logic xtal_osc_clk,
   input wire logic lfint_osc_clk,
   input wire logic ladder_phase_b,
   output logic [3:0] com_drive,
   output logic [23:0] seg_dark,
   output logic [23:0] seg_func,
   output logic drive_phase,
   output logic bias_half,
   output lcdsd_pkg::lcdsd_analog_t analog,
   output logic irq
);
   // ****************************************************
   // Registers
   // ****************************************************
   logic [7:0] main_q;
   logic [7:0] phase_q;
   logic [7:0] ref_q;
   logic [2:0] contrast_q;
   logic [7:0] segen_q [lcdsd_pkg::SEG_REGS];
   logic [7:0] data_q [lcdsd_pkg::DATA_REGS];
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   logic [7:0] rdata_q;
   logic write_error_flag_q;
   logic active_q;
   logic [7:0] sysdiv_q;
   logic [2:0] xtal_sync_q;
   logic [2:0] lfint_sync_q;
   logic [3:0] pre_q;
   logic [1:0] com_q;
   logic phase_q_r;
   lcdsd_pkg::lcdsd_state_t state_q;
   logic [3:0] com_drive_q;
   logic [23:0] seg_dark_q;
   lcdsd_pkg::lcdsd_analog_t analog_q;

   // ****************************************************
   // Address decode
   // ****************************************************
   wire logic hit_main = reg_addr == lcdsd_pkg::ADDR_MAIN;
   wire logic hit_phase = reg_addr == lcdsd_pkg::ADDR_PHASE;
   wire logic hit_ref = reg_addr == lcdsd_pkg::ADDR_REF;
   wire logic hit_contrast = reg_addr == lcdsd_pkg::ADDR_CONTRAST;
   wire logic hit_stat = reg_addr == lcdsd_pkg::ADDR_IRQ_STATUS;
   wire logic hit_mask = reg_addr == lcdsd_pkg::ADDR_IRQ_MASK;
   wire logic [7:0] seg_off = reg_addr - lcdsd_pkg::ADDR_SEGEN0;
   wire logic [7:0] data_off = reg_addr - lcdsd_pkg::ADDR_DATA0;
   wire logic hit_seg = seg_off < 8'(lcdsd_pkg::SEG_REGS);
   wire logic hit_data = data_off < 8'(lcdsd_pkg::DATA_REGS);

   // ****************************************************
   // Field views
   // ****************************************************
   wire logic mod_en = main_q[lcdsd_pkg::MAIN_EN];
   wire logic slp_dis = main_q[lcdsd_pkg::MAIN_SLP];
   wire logic [1:0] clk_src = main_q[lcdsd_pkg::MAIN_CS +: 2];
   wire logic [1:0] lmux = main_q[1:0];
   wire logic waveform_type_bit = phase_q[lcdsd_pkg::PHASE_WFT];
   wire logic bias_md = phase_q[lcdsd_pkg::PHASE_BIAS];
   wire logic [3:0] prescale = phase_q[3:0];

   // Driver runs when enabled and not held off by sleep
   wire logic active_d = mod_en & ~(cpu_sleep & slp_dis);

   // ****************************************************
   // Clock source selection
   // ****************************************************
   // Edges taken from the second stage against a third, never the first
   wire logic xtal_tick = xtal_sync_q[1] & ~xtal_sync_q[2];
   wire logic lfint_tick = lfint_sync_q[1] & ~lfint_sync_q[2];
   wire logic sys_tick = sysdiv_q == lcdsd_pkg::SYS_DIV_LAST;
   // Steps only once the scan state has left idle, so no tick is lost to the counter clear
   wire logic scanning = state_q == lcdsd_pkg::ST_SCAN;
   wire logic src_tick = (clk_src == lcdsd_pkg::CS_SYS) ? sys_tick :
                         (clk_src == lcdsd_pkg::CS_XTAL) ? xtal_tick : lfint_tick;
   wire logic frame_tick = active_q & scanning & src_tick & (pre_q == prescale);
   wire logic last_com = com_q == lmux;

   // Writes to pixel data are refused in the cycle the scan latches a common
   wire logic write_allow = ~(active_q & frame_tick);
   wire logic data_wr = reg_wr & hit_data;
   wire logic write_error_flag_set = data_wr & ~write_allow;

   // ****************************************************
   // Read mux
   // ****************************************************
   wire logic [7:0] phase_rd = {phase_q[7:6], active_q, write_allow, phase_q[3:0]};
   wire logic [7:0] main_rd = {main_q[7:6], write_error_flag_q, 1'b0, main_q[3:0]};
   wire logic [7:0] rd_mux = hit_main ? main_rd :
                            hit_phase ? phase_rd :
                            hit_ref ? {ref_q[7:5], 1'b0, ref_q[3:1], 1'b0} :
                            hit_contrast ? {5'h00, contrast_q} :
                            hit_seg ? segen_q[seg_off[1:0]] :
                            hit_data ? data_q[data_off[3:0]] :
                            hit_stat ? {6'h00, irq_stat_q} :
                            hit_mask ? {6'h00, irq_mask_q} : 8'h00;

   // ****************************************************
   // Pixel selection for the current common
   // ****************************************************
   wire logic [3:0] row_base = {1'b0, com_q, 1'b0} + {2'h0, com_q};
   wire logic [23:0] row_bits = {data_q[row_base + 4'h2], data_q[row_base + 4'h1], data_q[row_base]};
   wire logic [23:0] seg_en_all = {segen_q[2], segen_q[1], segen_q[0]};

   // Control registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         main_q <= {6'h00, lcdsd_pkg::LMUX_RESET};
         phase_q <= {4'h0, lcdsd_pkg::PRESCALE_RESET};
         ref_q <= 8'h00;
         contrast_q <= 3'h0;
         irq_mask_q <= 2'h0;
      end
      else if (reg_wr)
      begin
         if (hit_main)
            main_q <= {reg_wdata[7:6], 2'h0, reg_wdata[3:0]};
         if (hit_phase)
            phase_q <= {reg_wdata[7:6], 2'h0, reg_wdata[3:0]};
         if (hit_ref)
            ref_q <= {reg_wdata[7:5], 1'b0, reg_wdata[3:1], 1'b0};
         if (hit_contrast)
            contrast_q <= reg_wdata[2:0];
         if (hit_mask)
            irq_mask_q <= reg_wdata[1:0];
      end
   end

   // Segment enables and pixel data, one flop group per entry
   genvar gi;
   generate
      for (gi = 0; gi < lcdsd_pkg::SEG_REGS; gi++)
      begin : g_seg
         always_ff @(posedge clk_sys)
         begin
            if (rst)
               segen_q[gi] <= 8'h00;
            else if (reg_wr && hit_seg && seg_off[1:0] == 2'(gi))
               segen_q[gi] <= reg_wdata;
         end
      end
      for (gi = 0; gi < lcdsd_pkg::DATA_REGS; gi++)
      begin : g_data
         // Refused writes leave the stored pixels unchanged
         always_ff @(posedge clk_sys)
         begin
            if (rst)
               data_q[gi] <= 8'h00;
            else if (data_wr && write_allow && data_off[3:0] == 4'(gi))
               data_q[gi] <= reg_wdata;
         end
      end
   endgenerate

   // Write error: clearable only, set wins over a clear in the same cycle
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         write_error_flag_q <= 1'b0;
      else if (write_error_flag_set)
         write_error_flag_q <= 1'b1;
      else if (reg_wr && hit_main && !reg_wdata[lcdsd_pkg::MAIN_WRITE_ERROR_FLAG])
         write_error_flag_q <= 1'b0;
   end

   // Interrupt status: read clears, new events win
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         irq_stat_q <= 2'h0;
      else
         irq_stat_q <= (irq_stat_q & {2{~(reg_rd & hit_stat)}}) | {frame_tick & last_com, write_error_flag_set};
   end

   // Read data stands one cycle after the strobe
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         rdata_q <= 8'h00;
      else
         rdata_q <= reg_rd ? rd_mux : 8'h00;
   end

   // Synchronisers and the fixed system divider
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         xtal_sync_q <= 3'h0;
         lfint_sync_q <= 3'h0;
         sysdiv_q <= 8'h00;
         active_q <= 1'b0;
      end
      else
      begin
         xtal_sync_q <= {xtal_sync_q[1:0], xtal_osc_clk};
         lfint_sync_q <= {lfint_sync_q[1:0], lfint_osc_clk};
         sysdiv_q <= sysdiv_q + 8'h01;
         active_q <= active_d;
      end
   end

   // Scan state: idle while inactive, stepping commons while active
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         state_q <= lcdsd_pkg::ST_IDLE;
      else
      begin
         unique case (state_q)
            lcdsd_pkg::ST_IDLE: if (active_q) state_q <= lcdsd_pkg::ST_SCAN;
            lcdsd_pkg::ST_SCAN: if (!active_q) state_q <= lcdsd_pkg::ST_IDLE;
            default: state_q <= lcdsd_pkg::ST_IDLE;
         endcase
      end
   end

   // Prescaler, common counter and drive phase
   // Type-A flips phase every common step, Type-B once per full frame
   always_ff @(posedge clk_sys)
   begin
      if (rst || state_q == lcdsd_pkg::ST_IDLE)
      begin
         pre_q <= 4'h0;
         com_q <= 2'h0;
         phase_q_r <= 1'b0;
      end
      else if (src_tick)
      begin
         pre_q <= frame_tick ? 4'h0 : pre_q + 4'h1;
         if (frame_tick)
         begin
            com_q <= last_com ? 2'h0 : com_q + 2'h1;
            if (!waveform_type_bit || last_com)
               phase_q_r <= ~phase_q_r;
         end
      end
   end

   // Pin drive: active common one-hot, dark pixels on enabled segments
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         com_drive_q <= 4'h0;
         seg_dark_q <= 24'h000000;
      end
      else
      begin
         com_drive_q <= active_q ? 4'h1 << com_q : 4'h0;
         seg_dark_q <= active_q ? row_bits & seg_en_all : 24'h000000;
      end
   end

   // Analog controls; all but the bias pin enables off while inactive
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         analog_q <= '0;
      else
      begin
         analog_q.ladder_on <= active_q;
         analog_q.ref_on <= active_q & ref_q[lcdsd_pkg::REF_IRE];
         analog_q.ref_src_fvr <= active_q & ref_q[lcdsd_pkg::REF_IRE] & ref_q[lcdsd_pkg::REF_IRS];
         analog_q.buf_off <= ~active_q | (ref_q[lcdsd_pkg::REF_IRI] & ladder_phase_b);
         analog_q.bias_pin_en <= ref_q[lcdsd_pkg::REF_PE +: 3];
         analog_q.contrast <= active_q ? contrast_q : 3'h0;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign reg_rdata = rdata_q;
   assign com_drive = com_drive_q;
   assign seg_dark = seg_dark_q;
   assign seg_func = seg_en_all;
   assign drive_phase = phase_q_r;
   assign bias_half = bias_md & (lmux == 2'h1 || lmux == 2'h2);
   assign analog = analog_q;
   assign irq = |(irq_stat_q & irq_mask_q);

   // ****************************************************
   // Assertions
   // ****************************************************
   property p_enable_follows;
      @(posedge clk_sys) disable iff (rst)
      !cpu_sleep ##1 !cpu_sleep |-> active_q == $past(mod_en);
   endproperty
   a_enable_follows: assert property (p_enable_follows) else $error("active does not follow enable");

   property p_sleep_halt;
      @(posedge clk_sys) disable iff (rst)
      (cpu_sleep && slp_dis) |=> !active_q;
   endproperty
   a_sleep_halt: assert property (p_sleep_halt) else $error("driver ran in sleep");

   property p_write_error_flag_set;
      @(posedge clk_sys) disable iff (rst)
      write_error_flag_set |=> write_error_flag_q ##1 (write_error_flag_q || $past(reg_wr && hit_main));
   endproperty
   a_write_error_flag_set: assert property (p_write_error_flag_set) else $error("write error not held");

   property p_write_error_flag_no_sw_set;
      @(posedge clk_sys) disable iff (rst)
      (!write_error_flag_q && !write_error_flag_set) |=> !write_error_flag_q;
   endproperty
   a_write_error_flag_no_sw_set: assert property (p_write_error_flag_no_sw_set) else $error("write error set by software");

   property p_seg_gate;
      @(posedge clk_sys) disable iff (rst)
      ##1 (seg_dark & ~$past(seg_en_all)) == 24'h000000;
   endproperty
   a_seg_gate: assert property (p_seg_gate) else $error("disabled segment driven");

   property p_pixel_map;
      @(posedge clk_sys) disable iff (rst)
      active_q |=> seg_dark[7:0] == ($past(data_q[row_base]) & $past(segen_q[0]));
   endproperty
   a_pixel_map: assert property (p_pixel_map) else $error("pixel data mismatch");

   property p_bias;
      @(posedge clk_sys) disable iff (rst)
      (lmux == 2'h0 || lmux == 2'h3) |-> !bias_half;
   endproperty
   a_bias: assert property (p_bias) else $error("half bias outside two or three commons");

   sequence s_tick_wait;
      frame_tick && prescale == 4'h0 && clk_src == lcdsd_pkg::CS_SYS;
   endsequence
   // Fixed divider: a 1:1 frame on the system source repeats every 256 clocks
   property p_prescale;
      @(posedge clk_sys) disable iff (rst)
      s_tick_wait |-> ##256 (frame_tick || !active_q || prescale != 4'h0 || clk_src != lcdsd_pkg::CS_SYS);
   endproperty
   a_prescale: assert property (p_prescale) else $error("frame tick off the fixed divide");

   property p_typeb_phase;
      @(posedge clk_sys) disable iff (rst)
      (frame_tick && waveform_type_bit && !last_com) |=> $stable(drive_phase);
   endproperty
   a_typeb_phase: assert property (p_typeb_phase) else $error("type B phase flipped mid frame");

   property p_inactive_off;
      @(posedge clk_sys) disable iff (rst)
      !active_q |=> !analog.ladder_on && !analog.ref_on && analog.contrast == 3'h0;
   endproperty
   a_inactive_off: assert property (p_inactive_off) else $error("analog on while inactive");

   property p_idle_buffer;
      @(posedge clk_sys) disable iff (rst)
      (ref_q[lcdsd_pkg::REF_IRI] && ladder_phase_b) |=> analog.buf_off;
   endproperty
   a_idle_buffer: assert property (p_idle_buffer) else $error("buffer on in ladder B phase");

   property p_com_step;
      @(posedge clk_sys) disable iff (rst)
      (frame_tick && !last_com) |=> com_q == $past(com_q) + 2'h1;
   endproperty
   a_com_step: assert property (p_com_step) else $error("common did not advance");
endmodule // lcdsd_top

// *** lcdsd_pkg.sv ***
// Constants, register map and carrier types of the segment LCD driver control block.
// Assumes a byte-wide register port on clk_sys and a single synchronous reset.
//
// Overview of operation
// - Module enable bit starts LCD operation; clearing it stops operation.
// - Sleep-disable bit 1 halts driver in sleep; 0 keeps driving in sleep.
// - Pixel write while write-allow is 0 sets sticky write error, cleared by software only.
// - Segment enable bit 1 gives pin segment function; 0 leaves general I/O.
// - Twelve pixel registers; index is three times common plus segment group.
// - Pixel bit 1 makes pixel dark; 0 leaves it clear.
// - Bias mode bit picks half or third bias for two or three commons.
// - Waveform type bit selects Type-A or Type-B phase changes.
// - Prescale field divides LCD clock by value plus one; resets to 1:4.
// - Internal reference enable switches the reference and contrast circuit on; code gates only ref_on and ref_src_fvr with it, not contrast.
// - Ladder-idle bit turns reference buffer off during ladder B phase.
// - Each bias pin enable connects its pin to the internal bias level.
// - Bias pin connection leaves pin direction and analog select untouched.
// - Contrast field sets ladder resistance to value over seven of maximum.
// - Clock source field picks system clock over 256, crystal or internal oscillator.
// - While module is inactive, reference ladder, contrast ladder and reference are off.
// - Reference source bit chooses I/O supply or triple fixed reference.
package lcdsd_pkg;
   // ****************************************************
   // Register map
   // ****************************************************
   localparam logic [7:0] ADDR_MAIN = 8'h00;
   localparam logic [7:0] ADDR_PHASE = 8'h01;
   localparam logic [7:0] ADDR_REF = 8'h02;
   localparam logic [7:0] ADDR_CONTRAST = 8'h03;
   localparam logic [7:0] ADDR_SEGEN0 = 8'h04;
   localparam logic [7:0] ADDR_DATA0 = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;
   localparam int SEG_REGS = 3;
   localparam int DATA_REGS = 12;
   // ****************************************************
   // Field positions and reset values
   // ****************************************************
   localparam int MAIN_EN = 7;
   localparam int MAIN_SLP = 6;
   localparam int MAIN_WRITE_ERROR_FLAG = 5;
   localparam int MAIN_CS = 2;
   localparam int PHASE_WFT = 7;
   localparam int PHASE_BIAS = 6;
   localparam int PHASE_ACT = 5;
   localparam int PHASE_WA = 4;
   localparam int REF_IRE = 7;
   localparam int REF_IRS = 6;
   localparam int REF_IRI = 5;
   localparam int REF_PE = 1;
   localparam logic [1:0] LMUX_RESET = 2'h3;
   localparam logic [3:0] PRESCALE_RESET = 4'h3;
   localparam logic [7:0] SYS_DIV_LAST = 8'hff; // Fixed divide by 256
   localparam int IRQ_WRITE_ERROR_FLAG = 0;
   localparam int IRQ_FRAME = 1;
   // ****************************************************
   // Types
   // ****************************************************
   typedef enum logic [1:0] {CS_SYS = 2'h0, CS_XTAL = 2'h1} lcdsd_cs_t;
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SCAN = 2'b10} lcdsd_state_t;
   typedef struct packed {
      logic ladder_on;
      logic ref_on;
      logic ref_src_fvr;
      logic buf_off;
      logic [2:0] bias_pin_en;
      logic [2:0] contrast;
   } lcdsd_analog_t;
endpackage

// *** lcdsd_glass_model.sv ***
// Passive LCD glass model: latches the dark pattern that each common line shows.
// Assumes one-hot common drive and registered segment outputs, all on clk_sys.
`timescale 1ns/1ps
module lcdsd_glass_model
(
   input wire logic clk_sys,
   input wire logic [3:0] com_drive,
   input wire logic [23:0] seg_dark,
   input wire logic [23:0] seg_func,
   output logic [3:0][23:0] pixel_q,
   output logic multi_com_q
);
   // Start blank, as an unpowered panel would
   initial
   begin
      pixel_q = '0;
      multi_com_q = 1'b0;
   end

   // A pixel only darkens while its common is driven; I/O pins never darken
   always @(posedge clk_sys)
   begin
      for (int c = 0; c < 4; c++)
         if (com_drive[c])
            pixel_q[c] <= seg_dark & seg_func;
      // Two commons at once would smear rows together
      if (com_drive != 4'h0 && !$onehot(com_drive))
         multi_com_q <= 1'b1;
   end
endmodule // lcdsd_glass_model

// *** lcd_segment_driver_control_test.sv ***
// Self-checking bench of the segment LCD driver control block and a glass model.
// Assumes the register map of lcdsd_pkg, a 100 MHz clk_sys and slow oscillator inputs.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module lcd_segment_driver_control_test;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [7:0] m;} lcdsd_row_t;
   logic clk_sys, rst, reg_wr, reg_rd, cpu_sleep, xtal_osc_clk, lfint_osc_clk, ladder_phase_b;
   logic drive_phase, bias_half, irq, multi_com_q, ph;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
   logic [3:0] com_drive, snap;
   logic [23:0] seg_dark, seg_func;
   logic [3:0][23:0] pixel_q;
   lcdsd_pkg::lcdsd_analog_t analog;
   int num_errors = 0, samples_checked = 0, n, t;
   int per[4] = '{256, 20, 30, 30};
   logic [7:0] dv[12];
   lcdsd_row_t rows[$], rst_rows[$];

   lcdsd_top lcdsd_top_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_sleep(cpu_sleep),
      .xtal_osc_clk(xtal_osc_clk), .lfint_osc_clk(lfint_osc_clk), .ladder_phase_b(ladder_phase_b),
      .com_drive(com_drive), .seg_dark(seg_dark), .seg_func(seg_func), .drive_phase(drive_phase),
      .bias_half(bias_half), .analog(analog), .irq(irq));
   lcdsd_glass_model lcdsd_glass_model_i (.clk_sys(clk_sys), .com_drive(com_drive),
      .seg_dark(seg_dark), .seg_func(seg_func), .pixel_q(pixel_q), .multi_com_q(multi_com_q));

   // Clocks; oscillator phases are offset so no edge meets a clk_sys edge
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial
   begin
      xtal_osc_clk = 1'b0;
      #3;
      forever #100 xtal_osc_clk = ~xtal_osc_clk;
   end
   initial
   begin
      lfint_osc_clk = 1'b0;
      #7;
      forever #150 lfint_osc_clk = ~lfint_osc_clk;
   end

   // Watchdog, far beyond the few thousand cycles the tests need
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      num_errors++;
      report_and_stop();
   end

   // Bus strobes: each edge assigns both, so back-to-back cycles never clash
   task automatic bw(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
   endtask
   task automatic idle(input int k);
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task automatic wrt(input logic [7:0] a, input logic [7:0] d);
      bw(a, d);
      idle(2);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 got = reg_rdata;
   endtask
   task automatic run_row(input lcdsd_row_t r, input bit wr_first);
      if (wr_first)
         wrt(r.a, r.d);
      rd(r.a);
      `CHK(got & r.m, r.e)
   endtask
   // Cycles until the active common next moves, bounded
   task automatic wait_step(output int k);
      logic [3:0] c;
      c = com_drive;
      k = 0;
      do
      begin
         @(posedge clk_sys);
         #1 k++;
      end
      while (com_drive === c && k < 5000);
   endtask
   task automatic report_and_stop();
      if (num_errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ****************************************************
   // Stimulus
   // ****************************************************
   initial
   begin
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      cpu_sleep = 1'b0;
      ladder_phase_b = 1'b0;
      // Write error not settable by software; write-allow status bit masked off
      rows = '{'{8'h00, 8'h2f, 8'h0f, 8'hff}, '{8'h01, 8'hff, 8'hcf, 8'hef},
         '{8'h01, 8'h00, 8'h00, 8'hef}, '{8'h02, 8'hff, 8'hee, 8'hff}, '{8'h03, 8'hff, 8'h07, 8'hff},
         '{8'h04, 8'hff, 8'hff, 8'hff}, '{8'h05, 8'h3c, 8'h3c, 8'hff}, '{8'h06, 8'hc3, 8'hc3, 8'hff},
         '{8'h21, 8'h03, 8'h03, 8'h03}, '{8'h30, 8'hff, 8'h00, 8'hff}};
      for (int i = 0; i < 12; i++)
      begin
         dv[i] = {i[3:0], ~i[3:0]};
         rows.push_back('{8'h10 + i[7:0], dv[i], dv[i], 8'hff});
      end
      rst_rows = '{'{8'h00, 8'h00, 8'h03, 8'hff}, '{8'h01, 8'h00, 8'h03, 8'hef},
         '{8'h02, 8'h00, 8'h00, 8'hff}, '{8'h03, 8'h00, 8'h00, 8'hff}, '{8'h04, 8'h00, 8'h00, 8'hff},
         '{8'h05, 8'h00, 8'h00, 8'hff}, '{8'h06, 8'h00, 8'h00, 8'hff}, '{8'h21, 8'h00, 8'h00, 8'h03}};
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      foreach (rows[i])
         run_row(rows[i], 1'b1);
      // Enable on the crystal source, four commons, then scan whole frames
      wrt(8'h00, 8'h87);
      repeat (6) wait_step(n);
      for (int c = 0; c < 4; c++)
         `CHK(pixel_q[c], {dv[3 * c + 2], dv[3 * c + 1], dv[3 * c]} & 24'hc33cff)
      `CHK(multi_com_q, 1'b0)
      `CHK(seg_func, 24'hc33cff)
      rd(8'h01);
      `CHK(got[5], 1'b1)
      `CHK(analog.ref_on, 1'b1)
      `CHK(analog.ref_src_fvr, 1'b1)
      `CHK(analog.bias_pin_en, 3'h7)
      `CHK(analog.contrast, 3'h7)
      // Buffer shut-off follows the ladder phase only while idle-enable is set
      for (int k = 0; k < 4; k++)
      begin
         wrt(8'h02, k[1] ? 8'hce : 8'hee);
         @(posedge clk_sys);
         ladder_phase_b <= k[0];
         idle(3);
         `CHK(analog.buf_off, k[0] & ~k[1])
      end
      wrt(8'h02, 8'h4e);
      `CHK(analog.ref_on, 1'b0)
      // Step period per clock source at 1:1, then 1:16
      for (int s = 0; s < 4; s++)
      begin
         wrt(8'h00, {4'h8, s[1:0], 2'h3});
         wait_step(n);
         wait_step(n);
         `CHK(n, per[s])
      end
      wrt(8'h00, 8'h87);
      wrt(8'h01, 8'h0f);
      wait_step(n);
      wait_step(n);
      `CHK(n, 320)
      // Phase flips over one 80-cycle frame: per common or per frame
      for (int w = 0; w < 2; w++)
      begin
         wrt(8'h01, {w[0], 7'h00});
         wait_step(n);
         t = 0;
         ph = drive_phase;
         repeat (80)
         begin
            @(posedge clk_sys);
            #1 t += (drive_phase !== ph);
            ph = drive_phase;
         end
         `CHK(t, w ? 1 : 4)
      end
      // Half bias only takes effect with two or three commons
      wrt(8'h01, 8'h40);
      for (int l = 0; l < 4; l++)
      begin
         wrt(8'h00, {6'h21, l[1:0]});
         `CHK(bias_half, (l == 1 || l == 2))
      end
      wrt(8'h01, 8'h00);
      // Sleep halts the scan only when the sleep-disable bit is set
      wrt(8'h00, 8'hc7);
      @(posedge clk_sys);
      cpu_sleep <= 1'b1;
      idle(5);
      snap = com_drive;
      t = 0;
      repeat (100)
      begin
         @(posedge clk_sys);
         #1 t += (com_drive !== snap);
      end
      `CHK(t, 0)
      wrt(8'h00, 8'h87);
      wait_step(n);
      wait_step(n);
      `CHK(n, 20)
      @(posedge clk_sys);
      cpu_sleep <= 1'b0;
      // Back-to-back pixel writes must collide with a step cycle
      repeat (60) bw(8'h10, 8'h5a);
      idle(1);
      rd(8'h00);
      `CHK(got[5], 1'b1)
      wrt(8'h21, 8'h00);
      `CHK(irq, 1'b0)
      wrt(8'h21, 8'h01);
      `CHK(irq, 1'b1)
      rd(8'h20);
      `CHK(got[0], 1'b1)
      wrt(8'h00, 8'h87);
      rd(8'h00);
      `CHK(got[5], 1'b0)
      idle(1);
      `CHK(irq, 1'b0)
      wrt(8'h21, 8'h02);
      repeat (5) wait_step(n);
      idle(1);
      `CHK(irq, 1'b1)
      rd(8'h20);
      `CHK(got[1], 1'b1)
      // Disable: scan stops and the analog side powers down
      wrt(8'h00, 8'h07);
      n = 0;
      while (com_drive !== 4'h0 && n < 2000)
      begin
         @(posedge clk_sys);
         #1 n++;
      end
      `CHK(com_drive, 4'h0)
      rd(8'h01);
      `CHK(got[5], 1'b0)
      `CHK(analog.ref_on, 1'b0)
      `CHK(analog.ladder_on, 1'b0)
      // Reset in mid-scan
      wrt(8'h00, 8'h87);
      wait_step(n);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      `CHK(com_drive, 4'h0)
      `CHK(seg_func, 24'h000000)
      `CHK(bias_half, 1'b0)
      `CHK(irq, 1'b0)
      `CHK(analog.buf_off, 1'b1)
      foreach (rst_rows[i])
         run_row(rst_rows[i], 1'b0);
      report_and_stop();
   end
endmodule // lcd_segment_driver_control_test
